// ### dv/usc_peer.sv
`default_nettype none
module usc_peer (
  // Clock
  input wire logic clock,
  // Lines
  output logic rxLine,
  input wire logic txLine,
  // Setup
  input var int bitClks,
  input wire logic rxInv,
  input wire logic txInv
);
  timeunit 1ns;
  timeprecision 1ns;
  logic bitVal = 1'b1;
  assign rxLine = bitVal ^ rxInv;
  task automatic sendBits(input logic [15:0] b, input int n);
    @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      bitVal <= b[i];
      repeat (bitClks) @(posedge clock);
    end
    bitVal <= 1'b1;
  endtask : sendBits
  // Samples each bit at its middle, counting from the first non-idle cycle
  task automatic catchBits(input int n, output logic [15:0] b, output logic ok);
    int w;
    b = 16'h0000;
    w = 0;
    while ((txLine ^ txInv) === 1'b1 && w < 4000)
    begin
      @(posedge clock);
      w++;
    end
    ok = (w < 4000);
    repeat (bitClks / 2) @(posedge clock);
    for (int i = 0; i < n; i++)
    begin
      b[i] = txLine ^ txInv;
      repeat (bitClks) @(posedge clock);
    end
  endtask : catchBits
endmodule : usc_peer
`default_nettype wire

// ### dv/usc_sva.sv
`default_nettype none
module usc_sva (
  // System
  input wire logic clock,
  input wire logic srst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side
  input wire logic serialTxLine,
  input wire logic serialTxEnable,
  input wire logic txEvent,
  input wire logic rxEvent
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wrTaken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read response missing");
  chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_write_closed: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open during response");
  chk_read_closed: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel open during response");
  chk_tx_event_pulse: assert property (txEvent |=> !txEvent)
    else $error("transmit event longer than one cycle");
  chk_rx_event_pulse: assert property (rxEvent |=> !rxEvent)
    else $error("receive event longer than one cycle");
  chk_reset_idle: assert property ($fell(srst) |-> serialTxLine && !serialTxEnable)
    else $error("transmit pin not idle after reset");
endmodule : usc_sva
bind usc_uart usc_sva usc_sva_inst (.clock, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .serialTxLine,
  .serialTxEnable, .txEvent, .rxEvent);
`default_nettype wire

// ### dv/usc_tb.sv
`include "usc_regs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [`USC_ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdData;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serialRxLine, serialTxLine, serialTxEnable, txEvent, rxEvent;
  logic rxInv = 1'b0, txInv = 1'b0;
  int bitClks = 16, fail_count = 0, comparisons = 0, txEvents = 0, rxEvents = 0;
  usc_uart #(.BAUD_DIV(1), .DEPTH(4)) usc_uart_inst (.clock, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialRxLine,
    .serialTxLine, .serialTxEnable, .txEvent, .rxEvent);
  usc_peer usc_peer_inst (.clock, .rxLine(serialRxLine), .txLine(serialTxLine), .bitClks,
    .rxInv, .txInv);
  initial
  begin
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    if (txEvent === 1'b1)
      txEvents <= txEvents + 1;
    if (rxEvent === 1'b1)
      rxEvents <= rxEvents + 1;
  end
  task automatic results();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic giveUp();
    $display("wrong value bus answer expected 1 seen 0");
    fail_count++;
    results();
  endtask : giveUp
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1)
      giveUp();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rdData = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1)
      giveUp();
  endtask : rd
  task automatic chkStat(input string nm, input logic [15:0] mask, input logic [15:0] exp);
    rd(`USC_OFS_STAT);
    chk(nm, {16'h0000, exp}, rdData & {16'h0000, mask});
  endtask : chkStat
  task automatic rxChk(input string nm, input logic [8:0] d);
    rd(`USC_OFS_RXDATA);
    chk(nm, {23'h00_0000, d}, rdData);
  endtask : rxChk
  // Line image of one frame: mode is {format, two stop bits}
  function automatic logic [15:0] frameOf(input logic [2:0] m, input logic [8:0] d,
    output int n);
    logic [15:0] f;
    f = 16'h0000;
    n = 1;
    for (int i = 0; i < ((m[2:1] == usc_pkg::USC_FMT_9N) ? 9 : 8); i++)
    begin
      f[n] = d[i];
      n++;
    end
    if (m[2:1] == usc_pkg::USC_FMT_8E || m[2:1] == usc_pkg::USC_FMT_8O)
    begin
      f[n] = ^d[7:0] ^ (m[2:1] == usc_pkg::USC_FMT_8O);
      n++;
    end
    f[n] = 1'b1;
    f[n + 1] = m[0];
    n = n + 1 + m[0];
    return f;
  endfunction : frameOf
  task automatic txCheck(input logic [8:0] d, input int n, input logic [15:0] f,
    input string nm);
    logic [15:0] got;
    logic ok;
    fork
      wr(`USC_OFS_TXDATA, {7'h00, d});
      usc_peer_inst.catchBits(n, got, ok);
    join
    chk(nm, {15'h0000, 1'b1, f}, {15'h0000, ok, got});
  endtask : txCheck
  task automatic rxSend(input logic [2:0] m, input logic [8:0] d, input logic [15:0] flip);
    int n;
    logic [15:0] f;
    f = frameOf(m, d, n);
    usc_peer_inst.sendBits(f ^ flip, n);
  endtask : rxSend
  task automatic t_reset();
    chkStat("status reset", 16'hFFFF, 16'h0110);
    rd(`USC_OFS_MODE);
    chk("mode reset", 32'h0000_0000, rdData);
    rd(8'h10);
    chk("unmapped resp", 32'(`USC_RESP_SLVERR), 32'(resp));
    wr(8'h10, 16'hFFFF);
    chk("unmapped write", 32'(`USC_RESP_SLVERR), 32'(resp));
  endtask : t_reset
  task automatic t_formats();
    logic [8:0] d;
    logic [15:0] f;
    int n;
    wr(`USC_OFS_STAT, 16'h0400);
    @(posedge clock);
    chk("pin owner", 32'h0000_0001, 32'(serialTxEnable));
    for (int m = 0; m < 8; m++)
    begin
      d = 9'h1B3 & ((m[2:1] == 2'b11) ? 9'h1FF : 9'h0FF);
      wr(`USC_OFS_MODE, 16'(m));
      f = frameOf(3'(m), d, n);
      txCheck(d, n, f, "tx frame");
      chk("tx events", 32'(m + 1), 32'(txEvents));
      rxSend(3'(m), d, 16'h0000);
      chkStat("rx flags", 16'h001D, 16'h0011);
      rxChk("rx data", d);
      chk("rx events", 32'(m + 1), 32'(rxEvents));
    end
  endtask : t_formats
  // Bit 9 is the parity bit of 8E1 and the first stop bit of 8N2
  task automatic t_errors();
    wr(`USC_OFS_MODE, 16'h0002);
    rxSend(3'h2, 9'h0B3, 16'h0200);
    wr(`USC_OFS_MODE, 16'h0001);
    rxSend(3'h1, 9'h0C4, 16'h0200);
    chkStat("head parity", 16'h000C, 16'h0008);
    rxChk("fifo order", 9'h0B3);
    chkStat("head framing", 16'h000C, 16'h0004);
    rxChk("framed data", 9'h0C4);
    chkStat("rx empty", 16'h0001, 16'h0000);
  endtask : t_errors
  task automatic t_overrun();
    int e;
    wr(`USC_OFS_MODE, 16'h0000);
    for (int s = 3; s >= 2; s--)
    begin
      wr(`USC_OFS_STAT, 16'h0400 | 16'(s << 6));
      e = rxEvents;
      for (int i = 0; i < 5; i++)
      begin
        rxSend(3'h0, 9'(8'h30 + i), 16'h0000);
        chk("level event", 32'(e + (i >= s)), 32'(rxEvents));
      end
      chkStat("overrun", 16'h0003, 16'h0003);
      rxChk("fifo head", 9'h030);
      wr(`USC_OFS_STAT, 16'h0400 | 16'(s << 6));
      chkStat("flushed", 16'h0003, 16'h0000);
    end
  endtask : t_overrun
  task automatic t_break();
    wr(`USC_OFS_STAT, 16'h0C00);
    txCheck(9'h0FF, 14, 16'h2000, "break frame");
    chkStat("break clear", 16'h0800, 16'h0000);
  endtask : t_break
  task automatic t_full();
    wr(`USC_OFS_STAT, 16'h0000);
    wr(`USC_OFS_STAT, 16'h0400);
    for (int i = 0; i < 5; i++)
    begin
      wr(`USC_OFS_TXDATA, 16'h0041);
      chkStat("tx full", 16'h0300, (i == 4) ? 16'h0200 : 16'h0000);
    end
    wr(`USC_OFS_STAT, 16'h0000);
    chkStat("tx flushed", 16'h0300, 16'h0100);
    chk("pin release", 32'h0000_0000, 32'(serialTxEnable));
  endtask : t_full
  task automatic t_addr();
    wr(`USC_OFS_MODE, 16'h0006);
    wr(`USC_OFS_STAT, 16'h0420);
    rxSend(3'h6, 9'h0AA, 16'h0000);
    chkStat("addr drop", 16'h0001, 16'h0000);
    rxSend(3'h6, 9'h1AA, 16'h0000);
    rxChk("addr keep", 9'h1AA);
    wr(`USC_OFS_MODE, 16'h0000);
    rxSend(3'h0, 9'h0AA, 16'h0000);
    rxChk("addr 8 bit", 9'h0AA);
  endtask : t_addr
  task automatic t_ratePol();
    logic [15:0] f;
    int n;
    wr(`USC_OFS_MODE, 16'h0008);
    bitClks = 4;
    f = frameOf(3'h0, 9'h05A, n);
    txCheck(9'h05A, n, f, "fast tx");
    rxSend(3'h0, 9'h03C, 16'h0000);
    rxChk("fast rx", 9'h03C);
    bitClks = 16;
    wr(`USC_OFS_MODE, 16'h0010);
    rxInv <= 1'b1;
    repeat (20) @(posedge clock);
    rxSend(3'h0, 9'h096, 16'h0000);
    rxChk("inverted rx", 9'h096);
    wr(`USC_OFS_STAT, 16'h4400);
    @(posedge clock);
    txInv = 1'b1;
    chk("tx idle", 32'h0000_0000, 32'(serialTxLine));
    f = frameOf(3'h0, 9'h069, n);
    txCheck(9'h069, n, f, "inverted tx");
  endtask : t_ratePol
  // Three characters back to back give 3, 1 and 2 events for selects 00, 01 and 10
  task automatic t_txIrq();
    int e;
    wr(`USC_OFS_MODE, 16'h1010);
    @(posedge clock);
    chk("infrared idle", 32'h0000_0001, 32'(serialTxLine));
    wr(`USC_OFS_MODE, 16'h1018);
    @(posedge clock);
    chk("infrared fast off", 32'h0000_0000, 32'(serialTxLine));
    wr(`USC_OFS_MODE, 16'h0010);
    for (int s = 0; s < 3; s++)
    begin
      wr(`USC_OFS_STAT, 16'h0400 | {s[1], 1'b0, s[0], 13'h0000});
      e = txEvents;
      repeat (3) wr(`USC_OFS_TXDATA, 16'h0011);
      repeat (600) @(posedge clock);
      chk("tx irq events", 32'(e + ((s == 0) ? 3 : s)), 32'(txEvents));
    end
  endtask : t_txIrq
  initial
  begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_formats();
    t_errors();
    t_overrun();
    t_break();
    t_full();
    t_addr();
    t_ratePol();
    t_txIrq();
    results();
  end
endmodule : tb
`default_nettype wire

// ### rtl/usc_pkg.sv
`default_nettype none
package usc_pkg;
  typedef enum logic [1:0] {
    USC_FMT_8N = 2'b00,
    USC_FMT_8E = 2'b01,
    USC_FMT_8O = 2'b10,
    USC_FMT_9N = 2'b11
  } usc_fmt_type;
  typedef enum logic [1:0] {
    USC_RX_IDLE = 2'b00,
    USC_RX_START = 2'b01,
    USC_RX_BITS = 2'b10
  } usc_rx_state_type;
endpackage : usc_pkg
`default_nettype wire

// ### rtl/usc_regs.svh
`ifndef USC_REGS_SVH
`define USC_REGS_SVH

`define USC_ADDR_W 8
`define USC_OFS_MODE 8'h00
`define USC_OFS_STAT 8'h04
`define USC_OFS_TXDATA 8'h08
`define USC_OFS_RXDATA 8'h0C

`define USC_MODE_INFRARED_CODEC_ENABLE 12
`define USC_MODE_RXINV 4
`define USC_MODE_HIRATE 3
`define USC_MODE_FMT_HI 2
`define USC_MODE_FMT_LO 1
`define USC_MODE_STOP 0
`define USC_MODE_RESET 16'h0000
`define USC_MODE_MASK 16'h101F

`define USC_STAT_TXIS1 15
`define USC_STAT_TXINV 14
`define USC_STAT_TXIS0 13
`define USC_STAT_BRK 11
`define USC_STAT_TXEN 10
`define USC_STAT_TXFULL 9
`define USC_STAT_SHIFTER_EMPTY_FLAG 8
`define USC_STAT_RXIS_HI 7
`define USC_STAT_RXIS_LO 6
`define USC_STAT_ADDRESS_DETECT_ENABLE 5
`define USC_STAT_RX_IDLE_FLAG 4
`define USC_STAT_PARITY_ERROR_FLAG 3
`define USC_STAT_FRAMING_ERROR_FLAG 2
`define USC_STAT_OVR 1
`define USC_STAT_RXDA 0

`define USC_TICKS_STD_LAST 4'hF
`define USC_TICKS_HS_LAST 4'h3
`define USC_TICKS_STD_HALF 4'h7
`define USC_TICKS_HS_HALF 4'h1
`define USC_IR_PULSE_TICKS 4'h3
`define USC_BREAK_ZEROS 12
`define USC_RESP_OKAY 2'b00
`define USC_RESP_SLVERR 2'b10

`endif

// ### rtl/usc_uart.sv
`include "usc_regs.svh"
`default_nettype none
module usc_uart #(
  parameter int BAUD_DIV = 1,
  parameter int DEPTH = 4
) (
  // System
  input wire logic clock,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic [`USC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [`USC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line
  input wire logic serialRxLine,
  output logic serialTxLine,
  output logic serialTxEnable,
  // Events
  output logic txEvent,
  output logic rxEvent
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] THREE_COUNT = CW'(3);
  localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);

  // Register state
  logic [15:0] modeReg;
  logic [1:0] txIrqSelect;
  logic txPolarityInvert;
  logic breakRequest;
  logic txEnable;
  logic [1:0] rxIrqSelect;
  logic addressDetectEnable;
  logic overrun;

  // Bus slave state
  logic awHeld;
  logic wHeld;
  logic [`USC_ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;

  // Oversample tick divider
  logic [15:0] divCount;
  logic tick;

  // Transmit state
  logic [8:0] txBuf [DEPTH];
  logic [PW-1:0] txRd;
  logic [PW-1:0] txWr;
  logic [CW-1:0] txCount;
  logic txBusy;
  logic txIsBreak;
  logic [13:0] txShift;
  logic [3:0] txBitsLeft;
  logic [3:0] txTick;

  // Receive state
  usc_pkg::usc_rx_state_type rxState;
  logic [10:0] rxBuf [DEPTH];
  logic [PW-1:0] rxRd;
  logic [PW-1:0] rxWr;
  logic [CW-1:0] rxCount;
  logic [11:0] rxShiftReg;
  logic [3:0] rxIdx;
  logic [3:0] rxTick;
  logic [3:0] irStretch;

  // Mode fields
  wire infraredCodecEnable = modeReg[`USC_MODE_INFRARED_CODEC_ENABLE];
  wire rxPolarityInvert = modeReg[`USC_MODE_RXINV];
  wire highRateSelect = modeReg[`USC_MODE_HIRATE];
  wire [1:0] frameFormatSelect = modeReg[`USC_MODE_FMT_HI:`USC_MODE_FMT_LO];
  wire stopCountSelect = modeReg[`USC_MODE_STOP];
  wire nineBit = frameFormatSelect == usc_pkg::USC_FMT_9N;
  wire hasParity = frameFormatSelect == usc_pkg::USC_FMT_8E
    || frameFormatSelect == usc_pkg::USC_FMT_8O;
  wire oddParity = frameFormatSelect == usc_pkg::USC_FMT_8O;
  wire irActive = infraredCodecEnable && !highRateSelect;
  wire [3:0] bitLast = highRateSelect ? `USC_TICKS_HS_LAST : `USC_TICKS_STD_LAST;
  wire [3:0] bitHalf = highRateSelect ? `USC_TICKS_HS_HALF : `USC_TICKS_STD_HALF;

  // Status flags
  wire txFullFlag = txCount == FULL_COUNT;
  wire shifterEmptyFlag = txCount == '0 && !txBusy;
  wire rxIdleFlag = rxState == usc_pkg::USC_RX_IDLE;
  wire rxDataAvailable = rxCount != '0;
  wire [10:0] rxHead = rxBuf[rxRd];
  wire parityErrorFlag = rxDataAvailable && rxHead[9];
  wire framingErrorFlag = rxDataAvailable && rxHead[10];

  wire [15:0] statusRead = {txIrqSelect[1], txPolarityInvert, txIrqSelect[0], 1'b0,
    breakRequest, txEnable, txFullFlag, shifterEmptyFlag, rxIrqSelect,
    addressDetectEnable, rxIdleFlag, parityErrorFlag, framingErrorFlag, overrun,
    rxDataAvailable};

  // Write decode
  wire wrFire = awHeld && wHeld && !s_axi_bvalid;
  wire wrMode = wrFire && wrAddr == `USC_OFS_MODE;
  wire wrStat = wrFire && wrAddr == `USC_OFS_STAT;
  wire wrTx = wrFire && wrAddr == `USC_OFS_TXDATA;
  wire wrMapped = wrMode || wrStat || wrTx || wrAddr == `USC_OFS_RXDATA;
  wire [15:0] wrMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}};
  wire [15:0] statMerged = (wrData[15:0] & wrMask) | (statusRead & ~wrMask);
  wire txPush = wrTx && wrStrb[0] && txEnable && !txFullFlag;
  wire rxFlush = wrStat && wrStrb[0] && overrun && !wrData[`USC_STAT_OVR];

  // Read decode
  wire rdFire = s_axi_arvalid && s_axi_arready;
  wire rdMode = s_axi_araddr == `USC_OFS_MODE;
  wire rdStat = s_axi_araddr == `USC_OFS_STAT;
  wire rdTx = s_axi_araddr == `USC_OFS_TXDATA;
  wire rdRx = s_axi_araddr == `USC_OFS_RXDATA;
  wire [31:0] rdMux = rdMode ? {16'h0000, modeReg}
    : rdStat ? {16'h0000, statusRead}
    : rdRx && rxDataAvailable ? {23'h00_0000, rxHead[8:0]} : 32'h0000_0000;
  wire rxPop = rdFire && rdRx && rxDataAvailable;

  // Transmit frame assembly
  wire [8:0] txHead = txBuf[txRd];
  wire parityBit = oddParity ? ~^txHead[7:0] : ^txHead[7:0];
  wire [13:0] frameData = nineBit ? {3'b111, txHead, 1'b0}
    : hasParity ? {3'b111, parityBit, txHead[7:0], 1'b0}
    : {4'b1111, txHead[7:0], 1'b0};
  wire [3:0] frameLen = 4'd10 + {3'b000, nineBit || hasParity}
    + {3'b000, stopCountSelect};
  wire [13:0] breakFrame = {1'b1, 12'h000, 1'b0};
  wire txStartBreak = !txBusy && txEnable && breakRequest;
  wire txStartData = !txBusy && txEnable && !breakRequest && txCount != '0;
  wire txBitEnd = txBusy && tick && txTick == bitLast;
  wire txFrameEnd = txBitEnd && txBitsLeft == 4'd1;
  wire txCurBit = txBusy ? txShift[0] : 1'b1;
  wire irPulse = txBusy && !txShift[0] && txTick < `USC_IR_PULSE_TICKS;
  wire nextTxLine = irActive ? (irPulse ? ~txPolarityInvert : txPolarityInvert)
    : txCurBit ^ txPolarityInvert;
  wire txLoadEmpties = txCount == CW'(1);
  wire next_txEvent = (txStartData && txIrqSelect == 2'b00)
    || (txStartData && txLoadEmpties && txIrqSelect == 2'b10)
    || (txFrameEnd && txCount == '0 && txIrqSelect == 2'b01);

  // Receive line conditioning
  wire rxNorm = serialRxLine ^ rxPolarityInvert;
  wire rxBit = irActive ? irStretch == 4'h0 : rxNorm;
  wire [3:0] rxFrameBits = 4'd9 + {3'b000, nineBit || hasParity}
    + {3'b000, stopCountSelect};
  wire rxSampleEnd = tick && rxState == usc_pkg::USC_RX_BITS && rxTick == bitLast;
  wire rxLastSample = rxSampleEnd && rxIdx == rxFrameBits - 4'd1;
  wire [11:0] rxDone = rxShiftReg | (12'h001 << rxIdx) & {12{rxBit}};
  wire [3:0] stopPos = nineBit || hasParity ? 4'd9 : 4'd8;
  wire [8:0] rxChar = nineBit ? rxDone[8:0] : {1'b0, rxDone[7:0]};
  wire rxParOk = !hasParity || (rxDone[8] == (oddParity ? ~^rxDone[7:0] : ^rxDone[7:0]));
  wire rxStop1 = rxDone[stopPos];
  wire rxStop2 = !stopCountSelect || rxDone[stopPos + 4'd1];
  wire rxAccept = !(addressDetectEnable && nineBit && !rxDone[8]);
  wire rxStore = rxLastSample && rxAccept && !overrun;
  wire rxOverflow = rxStore && rxCount == FULL_COUNT && !rxPop;
  wire rxPush = rxStore && !rxOverflow;
  wire [CW-1:0] rxNewCount = rxCount + CW'(1);
  wire next_rxEvent = rxPush && (!rxIrqSelect[1]
    || (rxIrqSelect == 2'b11 && rxNewCount - CW'(rxPop) == FULL_COUNT)
    || (rxIrqSelect == 2'b10 && rxNewCount - CW'(rxPop) == THREE_COUNT));

  // Bus slave handshakes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `USC_RESP_OKAY;
      wrAddr <= '0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `USC_RESP_OKAY;
    end
    else if (rdFire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= (rdMode || rdStat || rdTx || rdRx) ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      modeReg <= `USC_MODE_RESET;
      txIrqSelect <= 2'b00;
      txPolarityInvert <= 1'b0;
      breakRequest <= 1'b0;
      txEnable <= 1'b0;
      rxIrqSelect <= 2'b00;
      addressDetectEnable <= 1'b0;
    end
    else
    begin
      if (txBusy && txIsBreak && txFrameEnd)
        breakRequest <= 1'b0;
      if (wrMode)
        modeReg <= ((wrData[15:0] & wrMask) | (modeReg & ~wrMask)) & `USC_MODE_MASK;
      if (wrStat)
      begin
        txIrqSelect <= {statMerged[`USC_STAT_TXIS1], statMerged[`USC_STAT_TXIS0]};
        txPolarityInvert <= statMerged[`USC_STAT_TXINV];
        breakRequest <= statMerged[`USC_STAT_BRK];
        txEnable <= statMerged[`USC_STAT_TXEN];
        rxIrqSelect <= statMerged[`USC_STAT_RXIS_HI:`USC_STAT_RXIS_LO];
        addressDetectEnable <= statMerged[`USC_STAT_ADDRESS_DETECT_ENABLE];
      end
    end
  end

  // Oversample tick, one pulse every BAUD_DIV clocks
  always_ff @(posedge clock)
  begin
    if (srst || divCount == DIV_LAST)
      divCount <= 16'h0000;
    else
      divCount <= divCount + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      tick <= 1'b0;
    else
      tick <= divCount == DIV_LAST;
  end

  // Transmit buffer and shifter
  always_ff @(posedge clock)
  begin
    if (txPush)
      txBuf[txWr] <= wrData[8:0];
  end

  always_ff @(posedge clock)
  begin
    if (srst || !txEnable)
    begin
      txRd <= '0;
      txWr <= '0;
      txCount <= '0;
      txBusy <= 1'b0;
      txIsBreak <= 1'b0;
      txShift <= 14'h3FFF;
      txBitsLeft <= 4'h0;
      txTick <= 4'h0;
    end
    else
    begin
      if (txPush)
        txWr <= txWr + PW'(1);
      txCount <= txCount + CW'(txPush) - CW'(txStartData);
      if (txStartBreak)
      begin
        txBusy <= 1'b1;
        txIsBreak <= 1'b1;
        txShift <= breakFrame;
        txBitsLeft <= 4'(`USC_BREAK_ZEROS + 2);
        txTick <= 4'h0;
      end
      else if (txStartData)
      begin
        txBusy <= 1'b1;
        txIsBreak <= 1'b0;
        txShift <= frameData;
        txBitsLeft <= frameLen;
        txTick <= 4'h0;
        txRd <= txRd + PW'(1);
      end
      else if (txBusy && tick)
      begin
        txTick <= txBitEnd ? 4'h0 : txTick + 4'h1;
        if (txBitEnd)
        begin
          txShift <= {1'b1, txShift[13:1]};
          txBitsLeft <= txBitsLeft - 4'h1;
          if (txFrameEnd)
            txBusy <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      serialTxLine <= 1'b1;
      serialTxEnable <= 1'b0;
      txEvent <= 1'b0;
    end
    else
    begin
      serialTxLine <= nextTxLine;
      serialTxEnable <= txEnable;
      txEvent <= next_txEvent && txEnable;
    end
  end

  // Infrared pulse stretcher holds a decoded zero for one bit
  always_ff @(posedge clock)
  begin
    if (srst || !irActive)
      irStretch <= 4'h0;
    else if (tick && !rxNorm)
      irStretch <= `USC_TICKS_STD_LAST;
    else if (tick && irStretch != 4'h0)
      irStretch <= irStretch - 4'h1;
  end

  // Receiver
  always_ff @(posedge clock)
  begin
    if (rxPush)
      rxBuf[rxWr] <= {!(rxStop1 && rxStop2), !rxParOk, rxChar};
  end

  always_ff @(posedge clock)
  begin
    if (srst || rxFlush)
    begin
      rxState <= usc_pkg::USC_RX_IDLE;
      rxRd <= '0;
      rxWr <= '0;
      rxCount <= '0;
      rxShiftReg <= 12'h000;
      rxIdx <= 4'h0;
      rxTick <= 4'h0;
      rxEvent <= 1'b0;
    end
    else
    begin
      rxEvent <= next_rxEvent;
      if (rxPop)
        rxRd <= rxRd + PW'(1);
      if (rxPush)
        rxWr <= rxWr + PW'(1);
      rxCount <= rxCount + CW'(rxPush) - CW'(rxPop);
      if (tick)
      begin
        unique case (rxState)
          usc_pkg::USC_RX_IDLE:
          begin
            rxTick <= 4'h0;
            if (!rxBit)
              rxState <= usc_pkg::USC_RX_START;
          end
          usc_pkg::USC_RX_START:
          begin
            rxTick <= rxTick + 4'h1;
            if (rxTick == bitHalf)
            begin
              rxTick <= 4'h0;
              rxIdx <= 4'h0;
              rxShiftReg <= 12'h000;
              rxState <= rxBit ? usc_pkg::USC_RX_IDLE : usc_pkg::USC_RX_BITS;
            end
          end
          usc_pkg::USC_RX_BITS:
          begin
            rxTick <= rxTick + 4'h1;
            if (rxSampleEnd)
            begin
              rxTick <= 4'h0;
              rxShiftReg <= rxDone;
              rxIdx <= rxIdx + 4'h1;
              if (rxLastSample)
                rxState <= usc_pkg::USC_RX_IDLE;
            end
          end
          default:
            rxState <= usc_pkg::USC_RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      overrun <= 1'b0;
    else if (rxOverflow)
      overrun <= 1'b1;
    else if (rxFlush)
      overrun <= 1'b0;
  end
endmodule : usc_uart
`default_nettype wire
